// *** common/asq_defines.svh ***
// register map, field positions, reset values and sizes of the converter sequencer
`ifndef ASQ_DEFINES_SVH
`define ASQ_DEFINES_SVH
`define ASQ_ADDR_W      8
`define ASQ_OFF_CTRL1   8'h00
`define ASQ_OFF_CTRL2   8'h04
`define ASQ_OFF_CTRL3   8'h08
`define ASQ_OFF_CHSEL   8'h0C
`define ASQ_OFF_SCAN    8'h10
`define ASQ_OFF_STAT    8'h14
`define ASQ_OFF_MASK    8'h18
`define ASQ_OFF_BUF     8'h80
`define ASQ_BUF_IDX     6:2
`define ASQ_HSIZE_WORD  3'h2
`define ASQ_NUM_CHAN    24
`define ASQ_RES_W       10
`define ASQ_C1_ON       15
`define ASQ_C1_SIDL     13
`define ASQ_C1_RESULT_FORMAT     9:8
`define ASQ_C1_TRIGGER_SOURCE     7:5
`define ASQ_C1_AUTO_SAMPLE_START     2
`define ASQ_C1_SAMPLE_ACTIVE     1
`define ASQ_C1_DONE     0
`define ASQ_C2_REFERENCE_CONFIG     15:13
`define ASQ_C2_SCAN     10
`define ASQ_C2_FILL_HALF_STATUS     7
`define ASQ_C2_SEQUENCES_PER_IRQ     6:2
`define ASQ_C2_SPLIT_BUFFER_MODE     1
`define ASQ_C2_ALTERNATE_MUX_MODE     0
`define ASQ_C3_RC_CLOCK_SELECT     15
`define ASQ_C3_AUTO_SAMPLE_TIME     12:8
`define ASQ_C3_CONV_CLOCK_DIVIDER     7:0
`define ASQ_CS_NEGB     15
`define ASQ_CS_POSB     12:8
`define ASQ_CS_NEGA     7
`define ASQ_CS_POSA     4:0
`define ASQ_EV_W        2
`define ASQ_EV_SEQ      0
`define ASQ_EV_CONV     1
`define ASQ_REG_RST     16'h0000
`endif

// *** common/asq_pkg.sv ***
// types shared by the converter sequencer modules
package asq_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_SAMPLE = 2'h1, ST_CONVERT = 2'h2} asq_state_t;
  typedef enum logic [2:0] {
    TRG_MANUAL = 3'h0, TRG_PIN = 3'h1, TRG_TMR_A = 3'h2, TRG_TMR_B = 3'h4,
    TRG_SENSE = 3'h6, TRG_AUTO = 3'h7
  } asq_trig_t;
  typedef enum logic [1:0] {FMT_INT = 2'h0, FMT_SINT = 2'h1, FMT_FRAC = 2'h2, FMT_SFRAC = 2'h3} asq_fmt_t;
endpackage

// *** common/asq_reg_if.sv ***
// register access strobes between the bus front end and the sequencer core
`timescale 1ns/1ps
`include "asq_defines.svh"
interface asq_reg_if;
  logic                   wr;
  logic                   rd;
  logic [`ASQ_ADDR_W-1:0] addr;
  logic [31:0]            wdata;
  logic [31:0]            rdata;
  modport bus  (output wr, rd, addr, wdata, input rdata);
  modport regs (input wr, rd, addr, wdata, output rdata);
endinterface

// *** logic/asq_ahb.sv ***
// bus slave front end: writes with no wait, reads with one wait state
`timescale 1ns/1ps
`include "asq_defines.svh"
module asq_ahb (
  input  logic        clk,
  input  logic        nrst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp,
  asq_reg_if.bus      ri
);
  typedef struct packed {
    logic                   pend_wr;
    logic                   pend_rd;
    logic [`ASQ_ADDR_W-1:0] addr;
    logic                   ready;
    logic                   resp;
    logic [31:0]            rdata;
  } asq_ahb_st_t;
  asq_ahb_st_t s_r;
  asq_ahb_st_t s_nxt;
  logic        take;

  always_comb begin
    s_nxt = s_r;
    take = hsel && htrans[1] && hready;
    ri.wr = s_r.pend_wr;
    ri.rd = s_r.pend_rd;
    ri.addr = s_r.addr;
    ri.wdata = hwdata;
    // narrow writes are completed but dropped
    s_nxt.pend_wr = take && hwrite && (hsize == `ASQ_HSIZE_WORD);
    s_nxt.pend_rd = take && !hwrite;
    s_nxt.resp = 1'b0;
    if (take) begin
      s_nxt.addr = haddr[`ASQ_ADDR_W-1:0];
    end
    // wait state lets a write in the previous data phase land before the read
    if (s_r.pend_rd) begin
      s_nxt.rdata = ri.rdata;
      s_nxt.ready = 1'b1;
    end
    if (take && !hwrite) begin
      s_nxt.ready = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '{ready: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.rdata;
  assign hreadyout = s_r.ready;
  assign hresp = s_r.resp;

  rd_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    (take && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
endmodule // asq_ahb

// *** logic/asq_tad.sv ***
// conversion clock divider: one-cycle tick per conversion clock period
`timescale 1ns/1ps
module asq_tad (
  input  logic       clk,
  input  logic       nrst,
  input  logic       en,
  input  logic       rc_sel,
  input  logic       rc_tick,
  input  logic [7:0] div,
  output logic       tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } asq_tad_st_t;
  asq_tad_st_t s_r;
  asq_tad_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!en) begin
      s_nxt.cnt = 8'h00;
    end else if (rc_sel) begin
      s_nxt.tick = rc_tick;
    end else if (s_r.cnt == div) begin
      s_nxt.cnt = 8'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

  tad_period_a: assert property (@(posedge clk) disable iff (!nrst)
    (en && !rc_sel && s_r.cnt == div && $stable(div)) |=> tick)
    else $error("conversion clock tick missed at end of divide period");
endmodule // asq_tad

// *** logic/asq_top.sv ***
// converter sequencer: registers, trigger, mux steering, result buffer, interrupt
`timescale 1ns/1ps
`include "asq_defines.svh"
// Behaviour
// - clearing converter_on wipes the result buffer and its fill position.
// - result_format picks integer, signed, fractional or signed fractional storage.
// - trigger_source picks what ends sampling and starts conversion.
// - reference_config 000/1xx rails, 001 ext positive, 010 ext negative, 011 both.
// - scan_enable steps mux A positive input through the scan-selected channels.
// - in split mode fill_half_status is 1 while the upper half fills.
// - sequences_per_irq plus one sequences complete before each interrupt.
// - split_buffer_mode gives two alternating 16-word halves, else one 32-word buffer.
// - alternate_mux_mode uses A first, then alternates B and A.
// - the scan steps through 24 analog channels, 0 through 23; the chsel positive fields reach 0 through 31.
// - stop_in_idle halts operation while the processor idles.
// - rc_clock_select picks the RC tick, else the divided system clock.
// - auto_sample_time sets 0 to 31 conversion clock periods of sampling.
// - conversion clock period is one plus conv_clock_divider system cycles.
module asq_top #(
  parameter int NUM_CHAN = `ASQ_NUM_CHAN
) (
  input  logic                  CLK,
  input  logic                  NRST,
  input  logic                  HSEL,
  input  logic [31:0]           HADDR,
  input  logic [1:0]            HTRANS,
  input  logic                  HWRITE,
  input  logic [2:0]            HSIZE,
  input  logic [31:0]           HWDATA,
  input  logic                  HREADY,
  output logic [31:0]           HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  input  logic                  IDLE_MODE,
  input  logic                  TRIG_PIN,
  input  logic                  TMR_A_MATCH,
  input  logic                  TMR_B_MATCH,
  input  logic                  SENSE_EVT,
  input  logic                  RC_TICK,
  input  logic [`ASQ_RES_W-1:0] CONV_RESULT,
  input  logic                  CONV_VALID,
  output logic                  CORE_ENABLE,
  output logic                  SAMPLE_HOLD,
  output logic                  CONV_START,
  output logic [4:0]            MUX_POS,
  output logic                  MUX_NEG,
  output logic                  VREF_POS_EXT,
  output logic                  VREF_NEG_EXT,
  output logic                  RC_CLK_SEL,
  output logic                  IRQ
);
  if (NUM_CHAN < 1 || NUM_CHAN > 32) begin : g_bad_chan
    $error("NUM_CHAN must lie in 1..32");
  end

  typedef struct packed {
    logic                    on;
    logic                    sidl;
    asq_pkg::asq_fmt_t       result_format;
    asq_pkg::asq_trig_t      trigger_source;
    logic                    auto_sample_start;
    logic                    sample_active;
    logic                    done;
    logic [2:0]              reference_config;
    logic                    scan_en;
    logic                    half;
    logic [4:0]              sequences_per_irq;
    logic                    split;
    logic                    alternate_mux_mode;
    logic                    rc_clock_select;
    logic [4:0]              auto_sample_time;
    logic [7:0]              conv_clock_divider;
    logic [15:0]             chsel;
    logic [NUM_CHAN-1:0]     scan;
    logic [`ASQ_EV_W-1:0]    stat;
    logic [`ASQ_EV_W-1:0]    mask;
    asq_pkg::asq_state_t     st;
    logic [4:0]              sample_active_cnt;
    logic [4:0]              seq_cnt;
    logic [4:0]              pos;
    logic [4:0]              scan_ptr;
    logic                    use_b;
    logic                    pin_d;
    logic                    start_o;
    logic                    sample_o;
    logic                    core_en;
    logic [4:0]              mux_pos;
    logic                    mux_neg;
    logic                    vp_ext;
    logic                    vn_ext;
    logic                    irq;
    logic [31:0][15:0]       buf_w;
  } asq_top_st_t;

  asq_top_st_t          s_r;
  asq_top_st_t          s_nxt;
  asq_reg_if            ri ();
  logic                 tad_tick;
  logic [`ASQ_EV_W-1:0] ev;
  logic                 halt;
  logic                 trig;
  logic                 store;
  logic [4:0]           wr_idx;
  logic [15:0]          wr_val;
  logic [31:0]          rd_word;

  function automatic logic [15:0] fmt_res(input asq_pkg::asq_fmt_t f,
                                          input logic [`ASQ_RES_W-1:0] d);
    unique case (f)
      asq_pkg::FMT_INT:   fmt_res = {6'h00, d};
      asq_pkg::FMT_SINT:  fmt_res = {{6{~d[9]}}, ~d[9], d[8:0]};
      asq_pkg::FMT_FRAC:  fmt_res = {d, 6'h00};
      asq_pkg::FMT_SFRAC: fmt_res = {~d[9], d[8:0], 6'h00};
    endcase
  endfunction

  // nearest selected channel after p, wrapping; channel 0 when none selected
  function automatic logic [4:0] next_chan(input logic [NUM_CHAN-1:0] m, input logic [4:0] p);
    logic [4:0] r;
    int         j;
    r = 5'h00;
    for (int k = NUM_CHAN; k >= 1; k--) begin
      j = (int'(p) + k) % NUM_CHAN;
      if (m[j]) begin
        r = 5'(j);
      end
    end
    return r;
  endfunction

  asq_ahb u_ahb (
    .clk       (CLK),
    .nrst      (NRST),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hsize     (HSIZE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .ri        (ri.bus)
  );

  asq_tad u_tad (
    .clk     (CLK),
    .nrst    (NRST),
    .en      (s_r.core_en),
    .rc_sel  (s_r.rc_clock_select),
    .rc_tick (RC_TICK),
    .div     (s_r.conv_clock_divider),
    .tick    (tad_tick)
  );

  // register read view
  always_comb begin
    rd_word = '0;
    if (ri.addr >= `ASQ_OFF_BUF) begin
      rd_word[15:0] = s_r.buf_w[ri.addr[`ASQ_BUF_IDX]];
    end else begin
      case (ri.addr)
        `ASQ_OFF_CTRL1: begin
          rd_word[`ASQ_C1_ON] = s_r.on;
          rd_word[`ASQ_C1_SIDL] = s_r.sidl;
          rd_word[`ASQ_C1_RESULT_FORMAT] = s_r.result_format;
          rd_word[`ASQ_C1_TRIGGER_SOURCE] = s_r.trigger_source;
          rd_word[`ASQ_C1_AUTO_SAMPLE_START] = s_r.auto_sample_start;
          rd_word[`ASQ_C1_SAMPLE_ACTIVE] = s_r.sample_active;
          rd_word[`ASQ_C1_DONE] = s_r.done;
        end
        `ASQ_OFF_CTRL2: begin
          rd_word[`ASQ_C2_REFERENCE_CONFIG] = s_r.reference_config;
          rd_word[`ASQ_C2_SCAN] = s_r.scan_en;
          rd_word[`ASQ_C2_FILL_HALF_STATUS] = s_r.half && s_r.split;
          rd_word[`ASQ_C2_SEQUENCES_PER_IRQ] = s_r.sequences_per_irq;
          rd_word[`ASQ_C2_SPLIT_BUFFER_MODE] = s_r.split;
          rd_word[`ASQ_C2_ALTERNATE_MUX_MODE] = s_r.alternate_mux_mode;
        end
        `ASQ_OFF_CTRL3: begin
          rd_word[`ASQ_C3_RC_CLOCK_SELECT] = s_r.rc_clock_select;
          rd_word[`ASQ_C3_AUTO_SAMPLE_TIME] = s_r.auto_sample_time;
          rd_word[`ASQ_C3_CONV_CLOCK_DIVIDER] = s_r.conv_clock_divider;
        end
        `ASQ_OFF_CHSEL: rd_word[15:0] = s_r.chsel;
        `ASQ_OFF_SCAN:  rd_word[NUM_CHAN-1:0] = s_r.scan;
        `ASQ_OFF_STAT:  rd_word[`ASQ_EV_W-1:0] = s_r.stat;
        `ASQ_OFF_MASK:  rd_word[`ASQ_EV_W-1:0] = s_r.mask;
        default:        rd_word = '0;
      endcase
    end
    ri.rdata = rd_word;
  end

  always_comb begin
    s_nxt = s_r;
    ev = '0;
    trig = 1'b0;
    store = 1'b0;
    s_nxt.start_o = 1'b0;
    s_nxt.pin_d = TRIG_PIN;
    wr_idx = s_r.split ? {s_r.half, s_r.pos[3:0]} : s_r.pos;
    wr_val = fmt_res(s_r.result_format, CONV_RESULT);
    if (ri.wr) begin
      case (ri.addr)
        `ASQ_OFF_CTRL1: begin
          s_nxt.on = ri.wdata[`ASQ_C1_ON];
          s_nxt.sidl = ri.wdata[`ASQ_C1_SIDL];
          s_nxt.result_format = asq_pkg::asq_fmt_t'(ri.wdata[`ASQ_C1_RESULT_FORMAT]);
          s_nxt.trigger_source = asq_pkg::asq_trig_t'(ri.wdata[`ASQ_C1_TRIGGER_SOURCE]);
          s_nxt.auto_sample_start = ri.wdata[`ASQ_C1_AUTO_SAMPLE_START];
          s_nxt.sample_active = ri.wdata[`ASQ_C1_SAMPLE_ACTIVE];
        end
        `ASQ_OFF_CTRL2: begin
          s_nxt.reference_config = ri.wdata[`ASQ_C2_REFERENCE_CONFIG];
          s_nxt.scan_en = ri.wdata[`ASQ_C2_SCAN];
          s_nxt.sequences_per_irq = ri.wdata[`ASQ_C2_SEQUENCES_PER_IRQ];
          s_nxt.split = ri.wdata[`ASQ_C2_SPLIT_BUFFER_MODE];
          s_nxt.alternate_mux_mode = ri.wdata[`ASQ_C2_ALTERNATE_MUX_MODE];
        end
        `ASQ_OFF_CTRL3: begin
          s_nxt.rc_clock_select = ri.wdata[`ASQ_C3_RC_CLOCK_SELECT];
          s_nxt.auto_sample_time = ri.wdata[`ASQ_C3_AUTO_SAMPLE_TIME];
          s_nxt.conv_clock_divider = ri.wdata[`ASQ_C3_CONV_CLOCK_DIVIDER];
        end
        `ASQ_OFF_CHSEL: s_nxt.chsel = ri.wdata[15:0];
        `ASQ_OFF_SCAN:  s_nxt.scan = ri.wdata[NUM_CHAN-1:0];
        `ASQ_OFF_MASK:  s_nxt.mask = ri.wdata[`ASQ_EV_W-1:0];
        default:        ;
      endcase
    end
    halt = s_nxt.sidl && IDLE_MODE;
    if (!s_nxt.on) begin
      s_nxt.buf_w = '0;
      s_nxt.pos = 5'h00;
      s_nxt.half = 1'b0;
      s_nxt.seq_cnt = 5'h00;
      s_nxt.st = asq_pkg::ST_IDLE;
      s_nxt.sample_active = 1'b0;
      s_nxt.done = 1'b0;
      s_nxt.use_b = 1'b0;
      s_nxt.scan_ptr = next_chan(s_nxt.scan, 5'(NUM_CHAN - 1));
    end else if (!halt) begin
      unique case (s_r.st)
        asq_pkg::ST_IDLE: begin
          if (s_nxt.sample_active) begin
            s_nxt.st = asq_pkg::ST_SAMPLE;
            s_nxt.sample_active_cnt = 5'h00;
          end
        end
        asq_pkg::ST_SAMPLE: begin
          if (tad_tick && s_r.sample_active_cnt < s_r.auto_sample_time) begin
            s_nxt.sample_active_cnt = s_r.sample_active_cnt + 5'h01;
          end
          case (s_r.trigger_source)
            asq_pkg::TRG_MANUAL: trig = !s_nxt.sample_active;
            asq_pkg::TRG_PIN:    trig = TRIG_PIN && !s_r.pin_d;
            asq_pkg::TRG_TMR_A:  trig = TMR_A_MATCH;
            asq_pkg::TRG_TMR_B:  trig = TMR_B_MATCH;
            asq_pkg::TRG_SENSE:  trig = SENSE_EVT;
            asq_pkg::TRG_AUTO:   trig = s_r.sample_active_cnt >= s_r.auto_sample_time;
            default:             trig = 1'b0; // reserved codes never convert
          endcase
          if (trig) begin
            s_nxt.sample_active = 1'b0;
            s_nxt.st = asq_pkg::ST_CONVERT;
            s_nxt.start_o = 1'b1;
            s_nxt.done = 1'b0;
          end else if (!s_nxt.sample_active) begin
            s_nxt.st = asq_pkg::ST_IDLE;
          end
        end
        asq_pkg::ST_CONVERT: begin
          if (CONV_VALID) begin
            store = 1'b1;
            s_nxt.buf_w[wr_idx] = wr_val;
            s_nxt.done = 1'b1;
            ev[`ASQ_EV_CONV] = 1'b1;
            s_nxt.st = asq_pkg::ST_IDLE;
            if (s_r.auto_sample_start) begin
              s_nxt.sample_active = 1'b1;
            end
            if (s_r.alternate_mux_mode) begin
              s_nxt.use_b = !s_r.use_b;
            end
            if (s_r.scan_en && !s_r.use_b) begin
              s_nxt.scan_ptr = next_chan(s_r.scan, s_r.scan_ptr);
            end
            if (s_r.seq_cnt == s_r.sequences_per_irq) begin
              ev[`ASQ_EV_SEQ] = 1'b1;
              s_nxt.seq_cnt = 5'h00;
              s_nxt.pos = 5'h00;
              s_nxt.half = s_r.split && !s_r.half;
              s_nxt.scan_ptr = next_chan(s_r.scan, 5'(NUM_CHAN - 1));
            end else begin
              s_nxt.seq_cnt = s_r.seq_cnt + 5'h01;
              s_nxt.pos = s_r.split ? {1'b0, s_r.pos[3:0] + 4'h1} : s_r.pos + 5'h01;
            end
          end
        end
      endcase
    end
    // a read clears status, but an event in the same cycle survives
    if (ri.rd && ri.addr == `ASQ_OFF_STAT) begin
      s_nxt.stat = ev;
    end else begin
      s_nxt.stat = s_r.stat | ev;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    s_nxt.core_en = s_nxt.on && !halt;
    s_nxt.sample_o = s_nxt.st == asq_pkg::ST_SAMPLE;
    s_nxt.mux_pos = s_nxt.use_b ? s_nxt.chsel[`ASQ_CS_POSB] :
                    (s_nxt.scan_en ? s_nxt.scan_ptr : s_nxt.chsel[`ASQ_CS_POSA]);
    s_nxt.mux_neg = s_nxt.use_b ? s_nxt.chsel[`ASQ_CS_NEGB] : s_nxt.chsel[`ASQ_CS_NEGA];
    s_nxt.vp_ext = !s_nxt.reference_config[2] && s_nxt.reference_config[0];
    s_nxt.vn_ext = !s_nxt.reference_config[2] && s_nxt.reference_config[1];
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign CORE_ENABLE = s_r.core_en;
  assign SAMPLE_HOLD = s_r.sample_o;
  assign CONV_START = s_r.start_o;
  assign MUX_POS = s_r.mux_pos;
  assign MUX_NEG = s_r.mux_neg;
  assign VREF_POS_EXT = s_r.vp_ext;
  assign VREF_NEG_EXT = s_r.vn_ext;
  assign RC_CLK_SEL = s_r.rc_clock_select;
  assign IRQ = s_r.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  buf_lost_a: assert property ($fell(s_r.on) |-> s_r.buf_w == '0 && s_r.pos == 5'h00)
    else $error("result buffer survived converter off");
  fmt_store_a: assert property (store && s_r.result_format == asq_pkg::FMT_SFRAC |->
    wr_val == {~CONV_RESULT[9], CONV_RESULT[8:0], 6'h00})
    else $error("signed fractional result misformatted");
  tmr_trig_a: assert property ((s_r.st == asq_pkg::ST_SAMPLE &&
    s_r.trigger_source == asq_pkg::TRG_TMR_A && TMR_A_MATCH && s_r.on && !IDLE_MODE && !ri.wr)
    |=> CONV_START && !SAMPLE_HOLD)
    else $error("timer match did not start a conversion");
  ref_rail_a: assert property (s_r.reference_config[2] |-> !VREF_POS_EXT && !VREF_NEG_EXT)
    else $error("upper reference codes must select the rails");
  scan_mux_a: assert property (s_r.on && s_r.scan_en && !s_r.use_b |->
    MUX_POS == s_r.scan_ptr)
    else $error("mux A positive input not following the scan pointer");
  half_flip_a: assert property (s_r.on && $changed(s_r.half) |->
    $past(s_r.split) && $past(s_r.seq_cnt) == $past(s_r.sequences_per_irq))
    else $error("fill half changed away from an interrupt point");
  irq_rate_a: assert property (ev[`ASQ_EV_SEQ] |-> s_r.seq_cnt == s_r.sequences_per_irq ##1
    s_r.stat[`ASQ_EV_SEQ])
    else $error("sequence interrupt at wrong count");
  split_pos_a: assert property (s_r.split && s_r.on |-> s_r.pos < 5'h10)
    else $error("split buffer position left its half");
  alt_first_a: assert property ($rose(s_r.on) |-> !s_r.use_b)
    else $error("first sample not on mux A");
  chan_range_a: assert property (int'(s_r.scan_ptr) < NUM_CHAN)
    else $error("scan pointer beyond last channel");
  idle_hold_a: assert property (s_r.on && s_r.sidl && IDLE_MODE && !ri.wr |=>
    $stable(s_r.st) && !CORE_ENABLE)
    else $error("sequencer moved while halted in idle");
  done_clr_a: assert property (CONV_START |-> !s_r.done)
    else $error("done still set at conversion start");
  auto_sample_active_a: assert property (store && s_r.auto_sample_start && !ri.wr |=> s_r.sample_active ##1 SAMPLE_HOLD)
    else $error("sampling not restarted after conversion");
endmodule // asq_top

// *** testbench/asq_core_model.sv ***
// converter core stand-in: answers each start with a result after a fixed latency
`timescale 1ns/1ps
module asq_core_model #(
  parameter int LAT = 5
) (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [9:0] val,
  output logic            valid,
  output logic [9:0]      result
);
  int cnt = 0;
  initial begin
    valid = 1'b0;
    result = 10'h000;
  end
  // result toggles outside its valid cycle so a stale capture shows up
  always @(posedge clk) begin
    valid <= 1'b0;
    result <= ~result;
    if (start) begin
      cnt <= LAT;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      valid <= 1'b1;
      result <= val;
    end
  end
endmodule // asq_core_model

// *** testbench/adc_sequencer_control_bench.sv ***
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
module adc_sequencer_control_bench;
  logic CLK = 0, NRST = 0, HSEL = 0, HWRITE = 0, IDLE_MODE = 0, rd_ph = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 0;
  logic HREADYOUT, HRESP, CONV_VALID, CORE_ENABLE, SAMPLE_HOLD, CONV_START;
  logic [4:0] MUX_POS;
  logic MUX_NEG, VREF_POS_EXT, VREF_NEG_EXT, RC_CLK_SEL, IRQ;
  logic [9:0] CONV_RESULT, val = 0;
  logic [9:0] d[4];
  logic [9:0] e[5];
  logic [4:0] ext = 5'h00;
  logic [4:0] mp[5] = '{5'h03, 5'h05, 5'h07, 5'h05, 5'h03};
  logic [31:0] q[$], v;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #50 CLK = ~CLK;
  asq_top u_dut (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IDLE_MODE(IDLE_MODE), .TRIG_PIN(ext[0]),
    .TMR_A_MATCH(ext[1]), .TMR_B_MATCH(ext[2]), .SENSE_EVT(ext[3]), .RC_TICK(ext[4]),
    .CONV_RESULT(CONV_RESULT), .CONV_VALID(CONV_VALID), .CORE_ENABLE(CORE_ENABLE),
    .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_START(CONV_START), .MUX_POS(MUX_POS), .MUX_NEG(MUX_NEG),
    .VREF_POS_EXT(VREF_POS_EXT), .VREF_NEG_EXT(VREF_NEG_EXT), .RC_CLK_SEL(RC_CLK_SEL),
    .IRQ(IRQ));
  asq_core_model u_core (.clk(CLK), .start(CONV_START), .val(val), .valid(CONV_VALID),
    .result(CONV_RESULT));
  task automatic print_verdict;
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single word transfer; a read notes its expected value for the monitor
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dat);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HSIZE <= 3'h2;
    HADDR <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= w ? dat : 32'h0;
    if (!w) q.push_back(dat);
    rd_ph <= !w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  always @(posedge CLK) begin
    if (rd_ph && HREADYOUT === 1'b1 && q.size() > 0) begin
      chk("hrdata", q.pop_front(), HRDATA);
      chk("hresp", 32'h0, {31'h0, HRESP});
    end
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      print_verdict();
    end
  end
  function automatic logic [31:0] fmt(input logic [1:0] f, input logic [9:0] x);
    case (f)
      asq_pkg::FMT_INT:  return {22'h0, x};
      asq_pkg::FMT_SINT: return {16'h0, {7{~x[9]}}, x[8:0]};
      asq_pkg::FMT_FRAC: return {16'h0, x, 6'h00};
      default:           return {16'h0, ~x[9], x[8:0], 6'h00};
    endcase
  endfunction
  initial begin
    void'($urandom(38179));
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    for (int i = 0; i < 3; i++) xfer(1'b0, 8'(4 * i), 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    v = {16'h0, 16'($urandom())};
    xfer(1'b1, 8'h08, v);
    xfer(1'b0, 8'h08, v & 32'h9FFF);
    chk("rc_clk_sel", {31'h0, v[15]}, {31'h0, RC_CLK_SEL});
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 8'h04, 32'(i) << 13);
      repeat (2) @(posedge CLK);
      chk("vref_pos", {31'h0, i == 1 || i == 3}, {31'h0, VREF_POS_EXT});
      chk("vref_neg", {31'h0, i == 2 || i == 3}, {31'h0, VREF_NEG_EXT});
    end
    // configure fully and clear the flag before anything converts
    xfer(1'b1, 8'h08, 32'h0001);
    xfer(1'b1, 8'h04, 32'h000C);
    xfer(1'b1, 8'h18, 32'h0001);
    xfer(1'b0, 8'h14, 32'h0);
    for (int f = 0; f < 4; f++) begin
      d[f] = 10'($urandom());
      val <= d[f];
      xfer(1'b1, 8'h00, 32'h80E2 | (32'(f) << 8));
      for (int n = 0; n < 300 && CONV_VALID !== 1'b1; n++) @(posedge CLK);
      repeat (3) @(posedge CLK);
    end
    xfer(1'b0, 8'h00, 32'h83E1);
    chk("irq_set", 32'h1, {31'h0, IRQ});
    for (int f = 0; f < 4; f++) xfer(1'b0, 8'(8'h80 + 4 * f), fmt(2'(f), d[f]));
    xfer(1'b0, 8'h14, 32'h3);
    @(posedge CLK);
    chk("irq_clr", 32'h0, {31'h0, IRQ});
    xfer(1'b1, 8'h00, 32'hA000);
    IDLE_MODE <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("core_en_idle", 32'h0, {31'h0, CORE_ENABLE});
    IDLE_MODE <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("core_en_run", 32'h1, {31'h0, CORE_ENABLE});
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b0, 8'h80, 32'h0);
    // scan 3/7/20, mux B on channel 5, split halves, four sequences per interrupt
    xfer(1'b1, 8'h0C, 32'h8502);
    xfer(1'b1, 8'h10, 32'h00100088);
    xfer(1'b1, 8'h04, 32'h040F);
    xfer(1'b1, 8'h00, 32'h8046);
    for (int k = 0; k < 5; k++) begin
      e[k] = 10'($urandom());
      val <= e[k];
      while (SAMPLE_HOLD !== 1'b1) @(posedge CLK);
      chk("mux_pos", {27'h0, mp[k]}, {27'h0, MUX_POS});
      chk("mux_neg", 32'(k & 1), {31'h0, MUX_NEG});
      ext[1] <= 1'b1;
      @(posedge CLK);
      ext[1] <= 1'b0;
      @(posedge CLK);
      chk("conv_start", 32'h1, {31'h0, CONV_START});
      chk("sample_hold", 32'h0, {31'h0, SAMPLE_HOLD});
      while (CONV_VALID !== 1'b1) @(posedge CLK);
    end
    xfer(1'b0, 8'h04, 32'h048F);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b0, 8'(8'h80 + 4 * (k < 4 ? k : 16)), fmt(2'h0, e[k]));
    end
    // let the monitor take the last read before the run ends
    @(posedge CLK);
    print_verdict();
  end
endmodule // adc_sequencer_control_bench
